//--- shared/fwpg_pkg.sv
// constants, opcode table and helpers for the flash write-enable and protection gate
package fwpg_pkg;

    // status byte layout
    localparam int ST_LOCK  = 7;
    localparam int ST_QE    = 6;
    localparam int ST_BP_HI = 5;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL   = 1;
    localparam int ST_BUSY  = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // block protection decode: 64KB blocks, address bits 23:16
    localparam int         BLK_HI    = 23;
    localparam int         BLK_LO    = 16;
    localparam logic [8:0] BLK_COUNT = 9'h100;
    localparam logic [3:0] BP_NONE   = 4'h0;
    localparam logic [3:0] BP_ALL    = 4'h9;

    // link framing
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [2:0] NB_MAX    = 3'h6;
    localparam logic [2:0] NB_OP     = 3'h1;
    localparam logic [2:0] NB_STATUS = 3'h2;
    localparam logic [2:0] ALEN_3    = 3'h3;
    localparam logic [2:0] ALEN_4    = 3'h4;
    localparam int         ARG_N     = 5;

    // latch control
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    // array program / erase, address checked
    localparam logic [7:0] OP_PAGE_PROGRAM_SINGLE    = 8'h02;
    localparam logic [7:0] OP_PAGE_PROGRAM_SINGLE_4B = 8'h12;
    localparam logic [7:0] OP_PAGE_PROGRAM_QUAD_A    = 8'h32;
    localparam logic [7:0] OP_PAGE_PROGRAM_QUAD_B    = 8'h38;
    localparam logic [7:0] OP_PAGE_PROGRAM_QUAD_4B_A = 8'h34;
    localparam logic [7:0] OP_PAGE_PROGRAM_QUAD_4B_B = 8'h3E;
    localparam logic [7:0] OP_SECTOR_ERASE_4K_A      = 8'hD7;
    localparam logic [7:0] OP_SECTOR_ERASE_4K_B      = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE_4K_4B     = 8'h21;
    localparam logic [7:0] OP_BLOCK_ERASE_32K        = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE_32K_4B     = 8'h5C;
    localparam logic [7:0] OP_BLOCK_ERASE_64K        = 8'hD8;
    localparam logic [7:0] OP_BLOCK_ERASE_64K_4B     = 8'hDC;
    // whole array, and the status register write
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    // register writes that need the latch
    localparam logic [7:0] OP_FUNCTION_REG_WRITE     = 8'h42;
    localparam logic [7:0] OP_READ_PARAM_WRITE_NV    = 8'h65;
    localparam logic [7:0] OP_READ_PARAM_WRITE_VOL   = 8'h63;
    localparam logic [7:0] OP_EXT_READ_PARAM_NV      = 8'h85;
    localparam logic [7:0] OP_EXT_READ_PARAM_VOL     = 8'h83;
    localparam logic [7:0] OP_INFO_ROW_ERASE         = 8'h64;
    localparam logic [7:0] OP_INFO_ROW_PROGRAM       = 8'h62;
    localparam logic [7:0] OP_BOOT_CONFIG_WRITE      = 8'h15;
    localparam logic [7:0] OP_BANK_ADDR_WRITE_NV     = 8'h18;
    localparam logic [7:0] OP_BANK_ADDR_WRITE_VOL    = 8'hC5;
    localparam logic [7:0] OP_DYNAMIC_PROT_WRITE     = 8'hFB;
    localparam logic [7:0] OP_DYNAMIC_PROT_WRITE_ALT = 8'hE1;
    localparam logic [7:0] OP_PERSISTENT_PROT_WRITE  = 8'hFD;
    localparam logic [7:0] OP_PERSIST_PROT_WRITE_4B  = 8'hE3;
    localparam logic [7:0] OP_PERSISTENT_PROT_ERASE  = 8'hE4;
    localparam logic [7:0] OP_PROTECTION_MODE_PROG   = 8'h2F;
    localparam logic [7:0] OP_PERSIST_LOCK_BIT_WRITE = 8'hA6;
    localparam logic [7:0] OP_FREEZE_SET             = 8'h91;
    localparam logic [7:0] OP_GANG_LOCK              = 8'h7E;
    localparam logic [7:0] OP_GANG_UNLOCK            = 8'h98;
    localparam logic [7:0] OP_PASSWORD_PROGRAM       = 8'hE8;
    // volatile writes taken without the latch
    localparam logic [7:0] OP_READ_PARAM_VOL_FREE = 8'hC0;
    localparam logic [7:0] OP_BANK_ADDR_VOL_FREE  = 8'h17;

    typedef enum logic [2:0] {
        CL_NONE, CL_SET, CL_CLEAR, CL_ARRAY, CL_CHIP, CL_STATUS, CL_REG, CL_FREE
    } fwpg_class_t;

    function automatic fwpg_class_t fwpg_classify(input logic [7:0] op);
        case (op)
            OP_WRITE_ENABLE:  return CL_SET;
            OP_WRITE_DISABLE: return CL_CLEAR;
            OP_PAGE_PROGRAM_SINGLE, OP_PAGE_PROGRAM_SINGLE_4B, OP_PAGE_PROGRAM_QUAD_A,
            OP_PAGE_PROGRAM_QUAD_B, OP_PAGE_PROGRAM_QUAD_4B_A, OP_PAGE_PROGRAM_QUAD_4B_B,
            OP_SECTOR_ERASE_4K_A, OP_SECTOR_ERASE_4K_B, OP_SECTOR_ERASE_4K_4B,
            OP_BLOCK_ERASE_32K, OP_BLOCK_ERASE_32K_4B, OP_BLOCK_ERASE_64K,
            OP_BLOCK_ERASE_64K_4B: return CL_ARRAY;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: return CL_CHIP;
            OP_STATUS_WRITE: return CL_STATUS;
            OP_FUNCTION_REG_WRITE, OP_READ_PARAM_WRITE_NV, OP_READ_PARAM_WRITE_VOL,
            OP_EXT_READ_PARAM_NV, OP_EXT_READ_PARAM_VOL, OP_INFO_ROW_ERASE,
            OP_INFO_ROW_PROGRAM, OP_BOOT_CONFIG_WRITE, OP_BANK_ADDR_WRITE_NV,
            OP_BANK_ADDR_WRITE_VOL, OP_DYNAMIC_PROT_WRITE, OP_DYNAMIC_PROT_WRITE_ALT,
            OP_PERSISTENT_PROT_WRITE, OP_PERSIST_PROT_WRITE_4B, OP_PERSISTENT_PROT_ERASE,
            OP_PROTECTION_MODE_PROG, OP_PERSIST_LOCK_BIT_WRITE, OP_FREEZE_SET,
            OP_GANG_LOCK, OP_GANG_UNLOCK, OP_PASSWORD_PROGRAM: return CL_REG;
            OP_READ_PARAM_VOL_FREE, OP_BANK_ADDR_VOL_FREE: return CL_FREE;
            default: return CL_NONE;
        endcase
    endfunction : fwpg_classify

    // opcodes that always carry a four-byte address
    function automatic logic fwpg_is_4b(input logic [7:0] op);
        return (op == OP_PAGE_PROGRAM_SINGLE_4B) || (op == OP_PAGE_PROGRAM_QUAD_4B_A) ||
               (op == OP_PAGE_PROGRAM_QUAD_4B_B) || (op == OP_SECTOR_ERASE_4K_4B) ||
               (op == OP_BLOCK_ERASE_32K_4B) || (op == OP_BLOCK_ERASE_64K_4B);
    endfunction : fwpg_is_4b

endpackage : fwpg_pkg

//--- src/fwpg_gate.sv
// write-enable latch, status register and protection gate for modifying flash commands
//
// How it works
// - single-line page program opcodes pass only with the enable latch set
// - quad page program opcodes, both address forms, need the enable latch
// - 4KB sector erase opcodes execute only with the enable latch set
// - 32KB block erase opcodes need the enable latch, else no erase
// - 64KB block erase opcodes need the enable latch, else no erase
// - chip erase, status, function and info row writes need the latch
// - read-parameter and extended read-parameter set commands need the latch
// - bank address and autoboot register writes need the latch
// - both dynamic protection write opcodes need the latch
// - persistent protection write and erase opcodes need the latch
// - protection mode, lock bit, freeze, gang and password commands need the latch
// - the two alternative volatile write opcodes pass without the latch
// - block-protect bits choose a region; program or erase there is refused
// - chip erase is refused while any block-protect bit is set
// - status lock bit clear: status writes allowed whatever the protect pin
// - lock bit set and protect pin low: status writes ignored
// - lock bit set and protect pin high: status writes allowed
// - quad enable clear: shared pins act as protect and hold inputs
// - quad enable set: shared pins become data lines two and three
// - latch clear blocks all write-class commands; latch set allows them
// - the write-enable opcode sets the latch
// - write-disable clears the latch, and so does completion of an operation
// - while busy, every command seen here is ignored
`timescale 1ns/1ps

module fwpg_gate
    import fwpg_pkg::*;
(
    // system clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // serial link, own clock
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        si_i,
    input  wire logic        wp_n_i,
    // configuration from the rest of the device
    input  wire logic        addr4_mode_i,
    input  wire logic        bottom_sel_i,
    input  wire logic        array_done_i,
    // status and pin role
    output logic      [7:0]  status_o,
    output logic             quad_io_en_o,
    // accepted command to the array engine
    output logic             op_start_o,
    output logic      [7:0]  op_code_o,
    output logic      [31:0] op_addr_o,
    output logic      [7:0]  op_data_o,
    output logic             cmd_reject_o
);

    // ---------------- link domain ----------------
    logic       link_rst_n;
    logic [2:0] bit_q;
    logic [2:0] nbyte_q;
    logic [6:0] shift_q;
    logic [7:0] op_q;
    logic [7:0] arg_q [ARG_N];
    logic [7:0] byte_in;
    logic [2:0] end_bit_q;
    logic [2:0] end_nbyte_q;
    logic       frame_tog_q;

    // frame counters restart whenever select is high, as the clock may stop there
    assign link_rst_n = arst_n_i & ~cs_n_i;
    assign byte_in    = {shift_q, si_i};

    // byte count after an edge; stops at the cap so a long program frame cannot wrap it
    function automatic logic [2:0] next_nbyte(input logic [2:0] bits, input logic [2:0] nb);
        return (bits == BIT_LAST && nb != NB_MAX) ? nb + 3'h1 : nb;
    endfunction : next_nbyte

    // bit and byte counters, mode 0 rising-edge sampling
    always_ff @(posedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_q   <= '0;
            nbyte_q <= '0;
        end else begin
            bit_q   <= bit_q + 3'h1;
            nbyte_q <= next_nbyte(bit_q, nbyte_q);
        end
    end

    // frame position kept after select rises, as the counters above clear then;
    // the toggle marks each clocked frame, so a bare select pulse cannot replay the last one
    always_ff @(posedge sck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            end_bit_q   <= '0;
            end_nbyte_q <= '0;
            frame_tog_q <= 1'b0;
        end else begin
            end_bit_q   <= bit_q + 3'h1;
            end_nbyte_q <= next_nbyte(bit_q, nbyte_q);
            if (bit_q == 3'h0 && nbyte_q == 3'h0) begin
                frame_tog_q <= ~frame_tog_q; // first edge of a frame
            end
        end
    end

    // serial shifter
    always_ff @(posedge sck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_q <= '0;
        end else begin
            shift_q <= byte_in[6:0];
        end
    end

    // opcode and first bytes after it; quad data beyond is not needed here
    always_ff @(posedge sck_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_q <= '0;
            for (int i = 0; i < ARG_N; i++) begin
                arg_q[i] <= '0;
            end
        end else if (bit_q == BIT_LAST) begin
            if (nbyte_q == 3'h0) begin
                op_q <= byte_in;
            end
            for (int i = 0; i < ARG_N; i++) begin
                if (nbyte_q == 3'(i + 1)) begin
                    arg_q[i] <= byte_in;
                end
            end
        end
    end

    // ---------------- system domain ----------------
    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    logic        wp_s1_q;
    logic        wp_s2_q;
    logic        frame_end;
    logic [7:0]  status_q;
    logic        seen_tog_q;
    logic        fresh;

    // select and protect pin each pass two flops before use
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= wp_n_i;
            wp_s2_q <= wp_s1_q;
        end
    end

    // the link words are still once select is high, so they are read here directly
    assign frame_end = cs_s2_q & ~cs_s3_q;

    // frame toggle taken over at each frame end; a difference means new bits came in
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_tog_q <= 1'b0;
        end else if (frame_end) begin
            seen_tog_q <= frame_tog_q;
        end
    end

    assign fresh = frame_tog_q ^ seen_tog_q;

    // block protection check over the selected region
    function automatic logic blk_protected(input logic [3:0] bp, input logic bottom,
                                           input logic [7:0] blk);
        logic [8:0] span;
        span = '0;
        if (bp == BP_NONE) begin
            return 1'b0;
        end
        if (bp >= BP_ALL) begin
            return 1'b1;
        end
        span = 9'h001 << (bp - 4'h1);
        if (bottom) begin
            return {1'b0, blk} < span;
        end
        return {1'b0, blk} >= (BLK_COUNT - span);
    endfunction : blk_protected

    fwpg_class_t cls;
    logic [2:0]  alen;
    logic [31:0] addr;
    logic [3:0]  bp;
    logic        write_enable_latch;
    logic        busy;
    logic        wp_low;
    logic        whole;
    logic        accept;
    logic        reject;
    logic        go_busy;

    // decision once the frame has closed
    always_comb begin
        cls     = fwpg_classify(op_q);
        alen    = (fwpg_is_4b(op_q) || addr4_mode_i) ? ALEN_4 : ALEN_3;
        addr    = (alen == ALEN_4) ? {arg_q[0], arg_q[1], arg_q[2], arg_q[3]}
                                   : {8'h00, arg_q[0], arg_q[1], arg_q[2]};
        bp      = status_q[ST_BP_HI:ST_BP_LO];
        write_enable_latch     = status_q[ST_WEL];
        busy    = status_q[ST_BUSY];
        wp_low  = ~status_q[ST_QE] & ~wp_s2_q;
        whole   = fresh && (end_bit_q == 3'h0) && (end_nbyte_q >= NB_OP);
        accept  = 1'b0;
        go_busy = 1'b0;
        case (cls)
            CL_ARRAY: begin
                accept = write_enable_latch && (end_nbyte_q > alen) && !blk_protected(bp, bottom_sel_i, addr[BLK_HI:BLK_LO]);
                go_busy = accept;
            end
            CL_CHIP: begin
                accept  = write_enable_latch && (bp == BP_NONE);
                go_busy = accept;
            end
            CL_STATUS: begin
                accept  = write_enable_latch && (end_nbyte_q >= NB_STATUS) && !(status_q[ST_LOCK] && wp_low);
                go_busy = accept;
            end
            CL_REG: begin
                accept  = write_enable_latch;
                go_busy = accept;
            end
            CL_FREE: begin
                accept = 1'b1;
            end
            default: begin
                accept = 1'b0;
            end
        endcase
        accept = accept && whole && !busy && frame_end;
        go_busy = go_busy && accept;
        reject  = frame_end && (cls != CL_NONE) && (cls != CL_SET) && (cls != CL_CLEAR) && !accept;
    end

    // status register: set of the latch never meets the clearing done, as set needs idle
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q <= STATUS_RST;
        end else begin
            if (frame_end && whole && !busy && cls == CL_SET) begin
                status_q[ST_WEL] <= 1'b1;
            end
            if (frame_end && whole && !busy && cls == CL_CLEAR) begin
                status_q[ST_WEL] <= 1'b0;
            end
            if (accept && cls == CL_STATUS) begin
                // latch and busy are not writable by the status write
                status_q[ST_LOCK:ST_BP_LO] <= arg_q[0][ST_LOCK:ST_BP_LO];
            end
            if (go_busy) begin
                status_q[ST_BUSY] <= 1'b1;
            end else if (busy && array_done_i) begin
                status_q[ST_BUSY] <= 1'b0;
                status_q[ST_WEL]  <= 1'b0;
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_start_o   <= 1'b0;
            cmd_reject_o <= 1'b0;
            op_code_o    <= '0;
            op_addr_o    <= '0;
            op_data_o    <= '0;
        end else begin
            op_start_o   <= accept;
            cmd_reject_o <= reject;
            if (accept) begin
                op_code_o <= op_q;
                op_addr_o <= addr;
                op_data_o <= arg_q[0];
            end
        end
    end

    // status mirror and pin role
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_o     <= STATUS_RST;
            quad_io_en_o <= 1'b0;
        end else begin
            status_o     <= status_q;
            quad_io_en_o <= status_q[ST_QE];
        end
    end

endmodule : fwpg_gate

//--- dv/fwpg_host.sv
// host controller model that drives the serial link of the write gate
`timescale 1ns/1ps
module fwpg_host (
    // link pins
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    // link idles deselected with the clock parked low
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // mode 0 frame, msb first; the clock only runs while selected
    task automatic send(input logic [47:0] b, input int n);
        for (int i = 0; i < n * 8; i++) begin
            si_o = b[47 - i];
            cs_n_o = 1'b0;
            #24;
            sck_o = 1'b1;
            #24;
            sck_o = 1'b0;
        end
        #24;
        cs_n_o = 1'b1;
        si_o = ~si_o; // released line must not keep showing the last bit
    endtask : send
endmodule : fwpg_host

//--- dv/fwpg_gate_properties.sv
// concurrent checks on the write gate ports
`timescale 1ns/1ps
module fwpg_gate_properties
    import fwpg_pkg::*;
(
    // watched ports
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    input wire logic        cs_n_i,
    input wire logic        wp_n_i,
    input wire logic        array_done_i,
    input wire logic [7:0]  status_o,
    input wire logic        quad_io_en_o,
    input wire logic        op_start_o,
    input wire logic [7:0]  op_code_o,
    input wire logic [7:0]  op_data_o,
    input wire logic        cmd_reject_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    logic gated;
    logic chip;
    // the two free volatile writes are the only accepted ones without the latch
    assign gated = (op_code_o != OP_READ_PARAM_VOL_FREE) && (op_code_o != OP_BANK_ADDR_VOL_FREE);
    assign chip  = (op_code_o == OP_CHIP_ERASE_A) || (op_code_o == OP_CHIP_ERASE_B);

    a_start_reject_excl: assert property (!(op_start_o && cmd_reject_o))
        else $error("accept and refuse in one cycle");
    a_start_one_cycle: assert property (op_start_o |=> !op_start_o)
        else $error("accept pulse too long");
    a_start_after_frame: assert property (op_start_o |-> $past(cs_n_i, 3) && $past(cs_n_i))
        else $error("accept before frame end");
    a_start_needs_latch: assert property (op_start_o && gated |-> status_o[ST_WEL])
        else $error("gated command accepted without latch");
    a_start_sets_busy: assert property (op_start_o && gated |=> status_o[ST_BUSY])
        else $error("accepted command did not set busy");
    a_busy_blocks_all: assert property (op_start_o |-> !status_o[ST_BUSY])
        else $error("command accepted while busy");
    a_chip_bp_clear: assert property (op_start_o && chip |-> status_o[ST_BP_HI:ST_BP_LO] == BP_NONE)
        else $error("chip erase accepted with protection set");
    a_lock_pin_guard: assert property (op_start_o && op_code_o == OP_STATUS_WRITE && status_o[ST_LOCK]
        && !status_o[ST_QE] |-> wp_n_i)
        else $error("status write accepted while locked");
    a_status_loaded: assert property (op_start_o && op_code_o == OP_STATUS_WRITE
        |=> status_o[7:2] == op_data_o[7:2])
        else $error("status bits not loaded from data");
    a_done_clears: assert property (array_done_i |-> ##2 status_o[1:0] == 2'h0)
        else $error("completion left latch or busy set");
    a_quad_pins: assert property ($rose(quad_io_en_o) |-> ##[0:1] status_o[ST_QE])
        else $error("pin role differs from quad bit");

    // main scenarios
    c_status_write: cover property (op_start_o && op_code_o == OP_STATUS_WRITE);
    c_refused_latched: cover property (cmd_reject_o && status_o[ST_WEL]);
    c_quad_on: cover property ($rose(quad_io_en_o));
endmodule : fwpg_gate_properties

bind fwpg_gate fwpg_gate_properties fwpg_gate_properties_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .cs_n_i(cs_n_i), .wp_n_i(wp_n_i), .array_done_i(array_done_i), .status_o(status_o),
    .quad_io_en_o(quad_io_en_o), .op_start_o(op_start_o), .op_code_o(op_code_o),
    .op_data_o(op_data_o), .cmd_reject_o(cmd_reject_o));

//--- dv/fwpg_gate_bench.sv
// self-checking bench for the write gate
`timescale 1ns/1ps
module fwpg_gate_bench
    import fwpg_pkg::*;
;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        wp_n_i = 1'b1;
    logic        addr4_mode_i = 1'b0;
    logic        bottom_sel_i = 1'b0;
    logic        array_done_i = 1'b0;
    wire logic   sck_i, cs_n_i, si_i;
    logic [7:0]  status_o, op_code_o, op_data_o;
    logic [31:0] op_addr_o;
    logic        quad_io_en_o, op_start_o, cmd_reject_o, st, rj;
    int          n_fail = 0;
    int          num_checks = 0;
    // every opcode that needs the latch
    logic [7:0]  gated [37] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20, 8'h21, 8'h52,
        8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h62,
        8'h15, 8'h18, 8'hC5, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8};

    always #25 mclk_i = ~mclk_i;

    fwpg_host fwpg_host_i (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));
    fwpg_gate fwpg_gate_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
        .si_i(si_i), .wp_n_i(wp_n_i), .addr4_mode_i(addr4_mode_i), .bottom_sel_i(bottom_sel_i),
        .array_done_i(array_done_i), .status_o(status_o), .quad_io_en_o(quad_io_en_o),
        .op_start_o(op_start_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o),
        .op_data_o(op_data_o), .cmd_reject_o(cmd_reject_o));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // one frame; the outcome pulses stand one cycle, so every cycle is looked at
    task automatic cmd(input logic [47:0] b, input int n, input logic xs, input logic xr);
        st = 1'b0;
        rj = 1'b0;
        fwpg_host_i.send(b, n);
        repeat (8) begin
            @(posedge mclk_i);
            #1;
            st |= (op_start_o === 1'b1);
            rj |= (cmd_reject_o === 1'b1);
        end
        chk("accept", {7'h0, st}, {7'h0, xs});
        chk("refuse", {7'h0, rj}, {7'h0, xr});
    endtask : cmd

    // latch set or clear frame, then the status it leaves
    task automatic latch(input logic [7:0] op, input logic [7:0] xst);
        fwpg_host_i.send({op, 40'h0}, 1);
        repeat (8) @(negedge mclk_i);
        chk("status", status_o, xst);
    endtask : latch

    // array engine reports completion
    task automatic op_done(input logic [7:0] xst);
        @(negedge mclk_i) array_done_i = 1'b1;
        @(negedge mclk_i) array_done_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        chk("status", status_o, xst);
    endtask : op_done

    initial begin
        repeat (4) @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        chk("status", status_o, 8'h00);
        // each gated opcode: refused cold, taken after the latch, latch gone at completion
        foreach (gated[k]) begin
            cmd({gated[k], 40'h0001000000}, 6, 1'b0, 1'b1);
            latch(OP_WRITE_ENABLE, 8'h02);
            cmd({gated[k], 40'h0001000000}, 6, 1'b1, 1'b0);
            chk("code", op_code_o, gated[k]);
            chk("status", status_o, 8'h03);
            op_done(8'h00);
        end
        cmd({OP_READ_PARAM_VOL_FREE, 40'h0}, 2, 1'b1, 1'b0);
        cmd({OP_BANK_ADDR_VOL_FREE, 40'h0}, 2, 1'b1, 1'b0);
        chk("status", status_o, 8'h00);
        latch(OP_WRITE_ENABLE, 8'h02);
        latch(OP_WRITE_DISABLE, 8'h00);
        // top block protected: top refused, bottom taken, chip erase refused
        latch(OP_WRITE_ENABLE, 8'h02);
        cmd({OP_STATUS_WRITE, 8'h04, 32'h0}, 2, 1'b1, 1'b0);
        op_done(8'h04);
        latch(OP_WRITE_ENABLE, 8'h06);
        cmd({8'h20, 24'hFF0000, 16'h0}, 4, 1'b0, 1'b1);
        chk("status", status_o, 8'h06);
        cmd({8'hC7, 40'h0}, 1, 1'b0, 1'b1);
        cmd({8'h20, 24'h000000, 16'h0}, 4, 1'b1, 1'b0);
        op_done(8'h04);
        @(negedge mclk_i) bottom_sel_i = 1'b1;
        latch(OP_WRITE_ENABLE, 8'h06);
        cmd({8'hD8, 24'h000000, 16'h0}, 4, 1'b0, 1'b1);
        // four address bytes: first byte is the top of the address
        @(negedge mclk_i) addr4_mode_i = 1'b1;
        cmd({8'hD8, 32'h12000000, 8'h0}, 5, 1'b0, 1'b1);
        cmd({8'hD8, 24'h01FF00, 16'h0}, 4, 1'b0, 1'b1);
        cmd({8'hD8, 32'h01FF0000, 8'h0}, 5, 1'b1, 1'b0);
        chk("addr", op_addr_o[31:24], 8'h01);
        chk("addr", op_addr_o[23:16], 8'hFF);
        op_done(8'h04);
        @(negedge mclk_i) addr4_mode_i = 1'b0;
        latch(OP_WRITE_ENABLE, 8'h06);
        cmd({8'hD8, 24'hFF0000, 16'h0}, 4, 1'b1, 1'b0);
        chk("addr", op_addr_o[31:24], 8'h00);
        chk("addr", op_addr_o[23:16], 8'hFF);
        op_done(8'h04);
        // protect pin low while unlocked: status write still taken
        @(negedge mclk_i) wp_n_i = 1'b0;
        latch(OP_WRITE_ENABLE, 8'h06);
        cmd({OP_STATUS_WRITE, 8'h80, 32'h0}, 2, 1'b1, 1'b0);
        op_done(8'h80);
        latch(OP_WRITE_ENABLE, 8'h82);
        cmd({OP_STATUS_WRITE, 8'h00, 32'h0}, 2, 1'b0, 1'b1);
        chk("status", status_o, 8'h82);
        @(negedge mclk_i) wp_n_i = 1'b1;
        cmd({OP_STATUS_WRITE, 8'h40, 32'h0}, 2, 1'b1, 1'b0);
        op_done(8'h40);
        chk("quad", {7'h0, quad_io_en_o}, 8'h01);
        latch(OP_WRITE_ENABLE, 8'h42);
        cmd({OP_STATUS_WRITE, 8'h00, 32'h0}, 2, 1'b1, 1'b0);
        op_done(8'h00);
        chk("quad", {7'h0, quad_io_en_o}, 8'h00);
        // while busy everything is ignored, latch clear included
        latch(OP_WRITE_ENABLE, 8'h02);
        cmd({8'h20, 24'h000000, 16'h0}, 4, 1'b1, 1'b0);
        latch(OP_WRITE_DISABLE, 8'h03);
        cmd({8'h02, 24'h000000, 16'h0}, 4, 1'b0, 1'b1);
        op_done(8'h00);
        conclude();
    end

    // the tests need well under a millisecond; twice that means a hang
    initial begin
        #2000000;
        n_fail++;
        conclude();
    end
endmodule : fwpg_gate_bench
